// ==== rtl/dfs_pkg.sv ====
package dfs_pkg;
    // widths and sizes
    localparam int IR_W = 4;
    localparam int OFS_W = 16;
    localparam int ADDR_W = 8;
    // instruction codes and capture pattern
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_IDCODE = 4'h2;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    // identification word, value is arbitrary
    localparam logic [31:0] ID_CODE_DEF = 32'h0000_0001;
    // four preset flag offsets picked at full reset
    localparam logic [15:0] PRESET_0 = 16'h0007;
    localparam logic [15:0] PRESET_1 = 16'h001f;
    localparam logic [15:0] PRESET_2 = 16'h003f;
    localparam logic [15:0] PRESET_3 = 16'h007f;
    // register byte addresses and bit positions
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_OFS = 8'h08;
    localparam int CTRL_LOCK = 0;
    localparam int CTRL_SNAP = 1;
    localparam int STAT_MODE = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_LOCK = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // test access port controller states
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008, ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020,
        ST_PSDR = 16'h0040, ST_EX2DR = 16'h0080, ST_UPDR = 16'h0100,
        ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000, ST_PSIR = 16'h2000, ST_EX2IR = 16'h4000,
        ST_UPIR = 16'h8000
    } dfs_tap_st_t;

    // next controller state from the sampled mode select
    function automatic dfs_tap_st_t dfs_tap_next(input dfs_tap_st_t s, input logic tms);
        case (s)
            ST_RESET: dfs_tap_next = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: dfs_tap_next = tms ? ST_SELDR : ST_IDLE;
            ST_SELDR: dfs_tap_next = tms ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: dfs_tap_next = tms ? ST_EX1DR : ST_SHDR;
            ST_SHDR: dfs_tap_next = tms ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: dfs_tap_next = tms ? ST_UPDR : ST_PSDR;
            ST_PSDR: dfs_tap_next = tms ? ST_EX2DR : ST_PSDR;
            ST_EX2DR: dfs_tap_next = tms ? ST_UPDR : ST_SHDR;
            ST_UPDR: dfs_tap_next = tms ? ST_SELDR : ST_IDLE;
            ST_SELIR: dfs_tap_next = tms ? ST_RESET : ST_CAPIR;
            ST_CAPIR: dfs_tap_next = tms ? ST_EX1IR : ST_SHIR;
            ST_SHIR: dfs_tap_next = tms ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: dfs_tap_next = tms ? ST_UPIR : ST_PSIR;
            ST_PSIR: dfs_tap_next = tms ? ST_EX2IR : ST_PSIR;
            ST_EX2IR: dfs_tap_next = tms ? ST_UPIR : ST_SHIR;
            ST_UPIR: dfs_tap_next = tms ? ST_SELDR : ST_IDLE;
            default: dfs_tap_next = ST_RESET;
        endcase
    endfunction
endpackage

// ==== rtl/dfs_tap_if.sv ====
`timescale 1ns/100ps
// carries the controller's steering and state between port and controller
interface dfs_tap_if;
    import dfs_pkg::*;
    logic tms;
    logic hold;
    dfs_tap_st_t state;
    modport fsm (input tms, input hold, output state);
    modport user (output tms, output hold, input state);
endinterface

// ==== rtl/dfs_tap_fsm.sv ====
`timescale 1ns/100ps
module dfs_tap_fsm
    import dfs_pkg::*;
(
    input wire logic link_clk, // test clock
    dfs_tap_if.fsm tap // steering in, state out
);
    dfs_tap_st_t state_r;

    // controller walk, held in its reset state while hold is high
    always_ff @(posedge link_clk) begin
        if (tap.hold) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= dfs_tap_next(state_r, tap.tms);
        end
    end

    assign tap.state = state_r;

    chk_tap_five_ones: assert property (@(posedge link_clk) disable iff (tap.hold)
        (tap.tms) [*5] |=> state_r == ST_RESET)
        else $error("five ones on mode select did not reach reset");
    chk_tap_one_hot: assert property (@(posedge link_clk) disable iff (tap.hold)
        !tap.hold |-> $onehot(state_r))
        else $error("controller state is not one-hot");
    cov_tap_shift_dr: cover property (@(posedge link_clk) disable iff (tap.hold)
        state_r == ST_CAPDR ##1 state_r == ST_SHDR [*3] ##1 state_r == ST_EX1DR);
endmodule

// ==== rtl/dfs_port.sv ====
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
// Function
// - select high: pins serve boundary scan only, no offset programming.
// - select low: scan disabled, pins program and read flag offsets.
// - rising clock with write enable low shifts one input bit into offsets; here no shift while the write lock is set.
// - rising clock with read enable low shifts one offset bit out.
// - scan: mode select and data sampled rising, outputs change falling.
// - scan: input data loads the selected instruction, id or bypass register.
// - scan: data out on falling edge, undriven outside shift states.
// - controller walks its states by mode select sampled on test clock.
// - undriven mode select and serial input read as high; this port has no pull-ups on tms or tdi.
// - full reset loads one of four presets into both offsets.
module dfs_port
    import dfs_pkg::*;
#(
    parameter int OW = OFS_W,
    parameter int IRW = IR_W,
    parameter logic [31:0] ID_CODE = ID_CODE_DEF
) (
    input wire logic aclk, // register bus clock
    input wire logic aresetn, // synchronous reset, low active
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic link_clk, // test clock or offset shift clock
    input wire logic tms, // test mode select
    input wire logic tdi, // test data in or serial offset in
    output logic tdo, // test data out or serial offset out
    output logic tdo_oe, // high while the port drives data out
    input wire logic port_function_select, // strap: high scan, low offsets
    input wire logic serial_write_enable_n, // offset shift-in enable
    input wire logic serial_read_enable_n, // offset shift-out enable
    input wire logic [1:0] default_offset_select, // strap: preset choice
    input wire logic full_reset_input_n, // full reset pin, low active
    output logic [OW-1:0] almost_empty_offset, // current empty offset
    output logic [OW-1:0] almost_full_offset // current full offset
);
    localparam int CW = 2 * OW;

    // preset offset for a strap setting
    function automatic logic [OW-1:0] preset_of(input logic [1:0] sel);
        case (sel)
            2'h0: preset_of = OW'(PRESET_0);
            2'h1: preset_of = OW'(PRESET_1);
            2'h2: preset_of = OW'(PRESET_2);
            default: preset_of = OW'(PRESET_3);
        endcase
    endfunction

    // true for a register address that exists
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_OFS);
    endfunction

    dfs_tap_if tap ();
    // link domain state
    logic frs_q1_r, frs_q2_r, frs_q3_r, rst_on_r;
    logic lk_q1_r, lk_q2_r, lk_q3_r, lock_t_r;
    logic rq_q1_r, rq_q2_r, rq_q3_r, ack_t_r;
    logic mode_jtag_r;
    logic [CW-1:0] chain_r;
    logic [CW:0] snap_t_r;
    logic [IRW-1:0] ir_sh_r, ir_r;
    logic [31:0] id_sh_r;
    logic byp_r;
    logic tdo_r, tdo_oe_r;
    // bus domain state
    logic ak_q1_r, ak_q2_r, ak_q3_r, ack_seen_r;
    logic req_a_r, lock_a_r;
    logic [CW:0] snap_a_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, wdata_r;
    logic [3:0] wstrb_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic aw_held_r, w_held_r;
    logic busy;

    // controller is held in reset during full reset and in offset mode
    assign tap.tms = tms;
    assign tap.hold = rst_on_r || !mode_jtag_r;

    dfs_tap_fsm u_tap (
        .link_clk(link_clk),
        .tap(tap)
    );

    // full reset pin crossed into the link domain
    always_ff @(posedge link_clk) begin
        frs_q1_r <= full_reset_input_n;
        frs_q2_r <= frs_q1_r;
        frs_q3_r <= frs_q2_r;
        if (frs_q2_r == frs_q3_r) begin
            rst_on_r <= !frs_q3_r;
        end
    end

    // write lock level crossed from the bus domain
    always_ff @(posedge link_clk) begin
        lk_q1_r <= lock_a_r;
        lk_q2_r <= lk_q1_r;
        lk_q3_r <= lk_q2_r;
        if (rst_on_r) begin
            lock_t_r <= 1'b0;
        end else if (lk_q2_r == lk_q3_r) begin
            lock_t_r <= lk_q3_r;
        end
    end

    // straps caught only while full reset is on
    always_ff @(posedge link_clk) begin
        if (rst_on_r) begin
            mode_jtag_r <= port_function_select;
        end
    end

    // offset chain: presets at reset, serial write wins over read
    always_ff @(posedge link_clk) begin
        if (rst_on_r) begin
            chain_r <= {preset_of(default_offset_select),
                        preset_of(default_offset_select)};
        end else if (!mode_jtag_r) begin
            if (!serial_write_enable_n && !lock_t_r) begin
                chain_r <= {tdi, chain_r[CW-1:1]};
            end else if (!serial_read_enable_n) begin
                chain_r <= {chain_r[0], chain_r[CW-1:1]};
            end
        end
    end

    assign almost_empty_offset = chain_r[OW-1:0];
    assign almost_full_offset = chain_r[CW-1:OW];
    // snapshot request toggle crossed in, snapshot taken, ack toggled back
    always_ff @(posedge link_clk) begin
        rq_q1_r <= req_a_r;
        rq_q2_r <= rq_q1_r;
        rq_q3_r <= rq_q2_r;
        if (rst_on_r) begin
            ack_t_r <= rq_q3_r;
        end else if (rq_q2_r == rq_q3_r && rq_q3_r != ack_t_r) begin
            snap_t_r <= {mode_jtag_r, chain_r};
            ack_t_r <= rq_q3_r;
        end
    end

    // instruction register: capture, shift, update
    always_ff @(posedge link_clk) begin
        if (tap.hold || tap.state == ST_RESET) begin
            ir_r <= IRW'(IR_IDCODE);
            ir_sh_r <= IRW'(IR_CAPTURE);
        end else if (tap.state == ST_CAPIR) begin
            ir_sh_r <= IRW'(IR_CAPTURE);
        end else if (tap.state == ST_SHIR) begin
            ir_sh_r <= {tdi, ir_sh_r[IRW-1:1]};
        end else if (tap.state == ST_UPIR) begin
            ir_r <= ir_sh_r;
        end
    end

    // data registers: id word or one-bit bypass, any other code is bypass
    always_ff @(posedge link_clk) begin
        if (tap.hold) begin
            id_sh_r <= ID_CODE;
            byp_r <= 1'b0;
        end else if (tap.state == ST_CAPDR) begin
            id_sh_r <= ID_CODE;
            byp_r <= 1'b0;
        end else if (tap.state == ST_SHDR) begin
            if (ir_r == IRW'(IR_IDCODE)) begin
                id_sh_r <= {tdi, id_sh_r[31:1]};
            end else begin
                byp_r <= tdi;
            end
        end
    end

    // data out changes on the falling edge only
    always_ff @(negedge link_clk) begin
        if (rst_on_r) begin
            tdo_r <= 1'b1;
            tdo_oe_r <= 1'b0;
        end else if (mode_jtag_r) begin
            tdo_oe_r <= (tap.state == ST_SHIR) || (tap.state == ST_SHDR);
            if (tap.state == ST_SHIR) begin
                tdo_r <= ir_sh_r[0];
            end else if (ir_r == IRW'(IR_IDCODE)) begin
                tdo_r <= id_sh_r[0];
            end else begin
                tdo_r <= byp_r;
            end
        end else begin
            tdo_oe_r <= 1'b1;
            tdo_r <= chain_r[0];
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;
    // ack toggle crossed into the bus domain, snapshot copied when it lands
    always_ff @(posedge aclk) begin
        ak_q1_r <= ack_t_r;
        ak_q2_r <= ak_q1_r;
        ak_q3_r <= ak_q2_r;
        if (!aresetn) begin
            ack_seen_r <= req_a_r;
            snap_a_r <= '0;
        end else if (ak_q2_r == ak_q3_r && ak_q3_r != ack_seen_r) begin
            ack_seen_r <= ak_q3_r;
            snap_a_r <= snap_t_r;
        end
    end

    assign busy = req_a_r != ack_seen_r;
    // write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awaddr_r <= s_axi_awaddr;
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end else if (aw_held_r && w_held_r && !bvalid_r) begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // control register: write lock and snapshot request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_a_r <= 1'b0;
            req_a_r <= 1'b0;
        end else if (aw_held_r && w_held_r && !bvalid_r && awaddr_r == ADDR_CTRL) begin
            if (wstrb_r[0]) begin
                lock_a_r <= wdata_r[CTRL_LOCK];
                if (wdata_r[CTRL_SNAP] && !busy) begin
                    req_a_r <= !req_a_r;
                end
            end
        end
    end

    // read channel: data registered one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (rvalid_r) begin
            if (s_axi_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == ADDR_CTRL) begin
                rdata_r <= 32'(lock_a_r);
            end else if (s_axi_araddr == ADDR_STAT) begin
                rdata_r <= 32'({lock_a_r, busy, snap_a_r[CW]});
            end else if (s_axi_araddr == ADDR_OFS) begin
                rdata_r <= 32'(snap_a_r[CW-1:0]);
            end else begin
                rdata_r <= '0;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    // link-side checks
    chk_scan_no_prog: assert property (@(posedge link_clk) disable iff (rst_on_r)
        mode_jtag_r |=> $stable(chain_r))
        else $error("offsets changed while in scan mode");
    chk_offset_tap_held: assert property (@(posedge link_clk) disable iff (rst_on_r)
        !mode_jtag_r |=> tap.state == ST_RESET)
        else $error("controller left reset in offset mode");
    chk_serial_shift_in: assert property (@(posedge link_clk) disable iff (rst_on_r)
        (!mode_jtag_r && !serial_write_enable_n && !lock_t_r)
        |=> chain_r[CW-1] == $past(tdi) && chain_r[CW-2:0] == $past(chain_r[CW-1:1]))
        else $error("serial input bit not shifted into offsets");
    chk_serial_shift_out: assert property (@(posedge link_clk) disable iff (rst_on_r)
        (!mode_jtag_r && serial_write_enable_n && !serial_read_enable_n)
        |=> chain_r == {$past(chain_r[0]), $past(chain_r[CW-1:1])})
        else $error("offset chain did not advance on read");
    chk_ir_shift_in: assert property (@(posedge link_clk) disable iff (rst_on_r)
        (mode_jtag_r && tap.state == ST_SHIR) |=> ir_sh_r[IRW-1] == $past(tdi))
        else $error("instruction register missed input bit");
    chk_tdo_idle_off: assert property (@(posedge link_clk) disable iff (rst_on_r)
        (mode_jtag_r && !$past(rst_on_r))
        |-> tdo_oe_r == (tap.state == ST_SHIR || tap.state == ST_SHDR))
        else $error("data out enable wrong for controller state");
    chk_tdo_ir_bit: assert property (@(posedge link_clk) disable iff (rst_on_r)
        (mode_jtag_r && !$past(rst_on_r) && tap.state == ST_SHIR) |-> tdo_r == ir_sh_r[0])
        else $error("data out does not show instruction bit");
    chk_preset_load: assert property (@(posedge link_clk)
        rst_on_r |=> almost_empty_offset == preset_of($past(default_offset_select))
        && almost_full_offset == almost_empty_offset)
        else $error("preset offset not loaded at full reset");
    cov_serial_write: cover property (@(posedge link_clk) disable iff (rst_on_r)
        (!mode_jtag_r && !serial_write_enable_n) [*8]);
    // bus-side checks
    chk_bresp_timing: assert property (@(posedge aclk) disable iff (!aresetn)
        (aw_held_r && w_held_r && !bvalid_r) |=> bvalid_r
        && bresp_r == (is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response missing one cycle after both halves");
    chk_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid_r && !s_axi_rready) |=> rvalid_r && $stable(rdata_r))
        else $error("read data dropped before it was taken");
    cov_unmapped_read: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && arready_r && !is_mapped(s_axi_araddr));
    cov_snapshot_done: cover property (@(posedge aclk) disable iff (!aresetn)
        busy ##[1:60] !busy);
endmodule

// ==== bench/dfs_host_model.sv ====
`timescale 1ns/100ps
// host or tester on the far side of the shared serial port
module dfs_host_model (
    output logic link_clk, // shift or test clock, stands low between frames
    output logic tms, // mode select, released high
    output logic tdi, // serial data, released high
    output logic serial_write_enable_n, // offset shift-in enable
    output logic serial_read_enable_n, // offset shift-out enable
    input wire logic tdo, // serial data from the port
    input wire logic tdo_oe // high while the port drives tdo
);
    logic free = 1'b0; // keeps the clock running outside frames
    logic pulse = 1'b0; // asks for one clock cycle
    // idle levels, then a clock made only on request, phase unrelated to the bus
    initial begin
        link_clk = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        serial_write_enable_n = 1'b1;
        serial_read_enable_n = 1'b1;
        #1.3;
        forever begin
            #3;
            if (free || pulse || link_clk) link_clk = ~link_clk;
        end
    end
    // one bit: lines change after the falling edge and hold through the rising one
    task automatic tick(input logic m, input logic d, input logic wn, input logic rn);
        tms = m;
        tdi = d;
        serial_write_enable_n = wn;
        serial_read_enable_n = rn;
        pulse = 1'b1;
        @(posedge link_clk);
        pulse = 1'b0;
        @(negedge link_clk);
    endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import dfs_pkg::*;
    localparam logic [31:0] ID_ARB = 32'h0000_5a5b; // arbitrary value
    logic aclk = 0, aresetn = 0, skip = 0, so_chk = 0, e1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v, w;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, default_offset_select = 0;
    logic link_clk, tms, tdi, tdo, tdo_oe, serial_write_enable_n, serial_read_enable_n;
    logic port_function_select = 0, full_reset_input_n = 1;
    logic [15:0] almost_empty_offset, almost_full_offset;
    logic [15:0] pre [4] = '{PRESET_0, PRESET_1, PRESET_2, PRESET_3};
    logic [33:0] exp_q [$];
    logic [33:0] e34;
    logic so_q [$];
    int checked = 0, n_mismatch = 0, seed = 78648;
    always #4 aclk = ~aclk;
    dfs_port #(.ID_CODE(ID_ARB)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk,
        .tms, .tdi, .tdo, .tdo_oe, .port_function_select, .serial_write_enable_n,
        .serial_read_enable_n, .default_offset_select, .full_reset_input_n,
        .almost_empty_offset, .almost_full_offset);
    dfs_host_model HOST (.link_clk, .tms, .tdi, .serial_write_enable_n,
        .serial_read_enable_n, .tdo, .tdo_oe);
    // bus answers against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            e34 = exp_q.pop_front();
            `CHK("bresp", e34[33:32], s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready && !skip) begin
            e34 = exp_q.pop_front();
            `CHK("rdata", e34, {s_axi_rresp, s_axi_rdata})
        end
    end
    // serial output as the host samples it at the rising edge
    always @(posedge link_clk) if (so_chk) begin
        e1 = so_q.pop_front();
        `CHK("tdo", e1, tdo)
        `CHK("tdo_oe", 1'b1, tdo_oe)
    end
    // one register access; the answer is awaited, never counted on
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r, input bit c);
        logic ka, kw, kd;
        if (c) exp_q.push_back({r, d});
        @(posedge aclk);
        skip <= !c; // changed off the edge at which the previous answer is checked
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        forever begin
            @(negedge aclk);
            ka = wr ? s_axi_awready : s_axi_arready;
            kw = s_axi_wready;
            kd = wr ? s_axi_bvalid : s_axi_rvalid;
            rd_v = s_axi_rdata;
            @(posedge aclk);
            if (ka && wr) s_axi_awvalid <= 0;
            if (kw && wr) s_axi_wvalid <= 0;
            if (ka && !wr) s_axi_arvalid <= 0;
            if (kd) break;
        end
        s_axi_bready <= 0;
        s_axi_rready <= 0;
    endtask
    // n link cycles, lsb first; c notes the expected serial output
    task automatic lk(input logic [63:0] mv, input logic [63:0] dv, input logic [63:0] ev,
        input int n, input bit c, input logic wn, input logic rn);
        for (int i = 0; i < n; i++) begin
            if (c) so_q.push_back(ev[i]);
            so_chk = c;
            HOST.tick(mv[i], dv[i], wn, rn);
        end
        so_chk = 0;
    endtask
    // full reset with straps held steady around it
    task automatic frst(input logic s, input logic [1:0] p);
        @(posedge aclk);
        port_function_select <= s;
        default_offset_select <= p;
        full_reset_input_n <= 0;
        lk('1, '1, 0, 10, 0, 1, 1);
        @(posedge aclk);
        full_reset_input_n <= 1;
        lk('1, '1, 0, 8, 0, 1, 1);
    endtask
    task automatic complete_run();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        #100000;
        n_mismatch++;
        $display("[ERR] watchdog expired");
        complete_run();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        for (int p = 0; p < 4; p++) begin
            frst(0, 2'(p));
            `CHK("ae", pre[p], almost_empty_offset)
            `CHK("af", pre[p], almost_full_offset)
        end
        w = $random(seed);
        lk('1, w, 0, 32, 0, 0, 1);
        `CHK("chain wr", w, {almost_full_offset, almost_empty_offset})
        lk('1, '1, w, 32, 1, 1, 0);
        `CHK("chain rd", w, {almost_full_offset, almost_empty_offset})
        $display("test offsets done");
        axi(1, ADDR_CTRL, 32'h1, RESP_OKAY, 1);
        axi(0, ADDR_CTRL, 32'h1, RESP_OKAY, 1);
        lk('1, '1, 0, 6, 0, 1, 1);
        lk('1, ~w, 0, 8, 0, 0, 1);
        `CHK("locked", w, {almost_full_offset, almost_empty_offset})
        // enables released before the clock runs free for the snapshot
        lk('1, '1, 0, 1, 0, 1, 1);
        axi(1, ADDR_CTRL, 32'h2, RESP_OKAY, 1);
        HOST.free = 1;
        rd_v = 32'h2;
        for (int k = 0; k < 200 && rd_v[STAT_BUSY]; k++)
            axi(0, ADDR_STAT, 0, RESP_OKAY, 0);
        HOST.free = 0;
        axi(0, ADDR_OFS, w, RESP_OKAY, 1);
        axi(0, ADDR_STAT, 0, RESP_OKAY, 1);
        axi(0, 8'h0c, 0, RESP_SLVERR, 1);
        axi(1, 8'h0c, 32'h1, RESP_SLVERR, 1);
        $display("test registers done");
        frst(1, 2'h0);
        `CHK("oe reset", 1'b0, tdo_oe)
        w = $random(seed);
        lk(4'b0010, '1, 0, 4, 0, 0, 0);
        lk(64'h8000_0000, w, ID_ARB, 32, 1, 0, 0);
        lk(5'b00111, '1, 0, 5, 0, 0, 0);
        lk(4'b1000, 4'hf, 4'h1, 4, 1, 0, 0);
        lk(4'b0011, '1, 0, 4, 0, 0, 0);
        lk(4'b1000, w, {w[2:0], 1'b0}, 4, 1, 0, 0);
        // five ones walk the controller back to reset, then one zero to idle
        lk(6'b011111, '1, 0, 6, 0, 0, 0);
        `CHK("oe idle", 1'b0, tdo_oe)
        `CHK("ae scan", pre[0], almost_empty_offset)
        $display("test scan done");
        complete_run();
    end
endmodule
